/* File: design/dmf_dsp_wrapper.sv */
`timescale 1ns/1ps
module dmf_dsp_wrapper #(
   parameter int N_SRC     = 16,
   parameter int CORE_SYSTEM_CLOCK_HZ = 20000000,
   parameter int MIX_COST  = 200
) (
   // Clock and reset
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   // AXI4-Lite write
   input  wire logic [dmf_pkg::AXI_AW-1:0]        s_awaddr,
   input  wire logic                              s_awvalid,
   output logic                                   s_awready,
   input  wire logic [dmf_pkg::AXI_DW-1:0]        s_wdata,
   input  wire logic [3:0]                        s_wstrb,
   input  wire logic                              s_wvalid,
   output logic                                   s_wready,
   output logic [1:0]                             s_bresp,
   output logic                                   s_bvalid,
   input  wire logic                              s_bready,
   // AXI4-Lite read
   input  wire logic [dmf_pkg::AXI_AW-1:0]        s_araddr,
   input  wire logic                              s_arvalid,
   output logic                                   s_arready,
   output logic [dmf_pkg::AXI_DW-1:0]             s_rdata,
   output logic [1:0]                             s_rresp,
   output logic                                   s_rvalid,
   input  wire logic                              s_rready,
   // Core sources toward the DSP
   input  wire logic [N_SRC-1:0][dmf_pkg::SAMPLE_W-1:0] src_data,
   input  wire logic                              src_valid,
   output logic                                   src_ready,
   // DSP input frame
   output dmf_pkg::dmf_in_frame_s                 dsp_in_frame,
   output logic                                   dsp_in_valid,
   input  wire logic                              dsp_in_ready,
   // DSP output frame and routing
   input  wire dmf_pkg::dmf_out_frame_s           dsp_out_frame,
   input  wire logic                              dsp_out_valid,
   output dmf_pkg::dmf_out_frame_s                route_out_frame,
   output logic                                   route_out_valid,
   output logic [dmf_pkg::RATE_W-1:0]             dsp_rate_select,
   // DSP flag writes
   input  wire logic                              dsp_flag_we,
   input  wire logic [1:0]                        dsp_flag_wdata,
   // Flags, events and GPIO
   output logic [1:0]                             dsp_flag_status,
   output logic                                   dsp_flag_one_host_irq,
   output logic                                   dsp_flag_two_host_irq,
   output logic                                   gpio_flag_out,
   output logic                                   underclock_err
);
   import dmf_pkg::*;

   // Bus state
   logic                  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic                  aw_held_q, w_held_q;
   logic [1:0]            bresp_q, rresp_q;
   logic [AXI_DW-1:0]     rdata_q, wdata_q;
   logic [3:0]            wstrb_q;
   logic [AXI_AW-1:0]     awaddr_q;
   // Register state
   logic [REG_W-1:0]      cfg_q [N_CFG];
   logic [1:0]            req_q, act_q;
   logic                  err_q, uc_err_q;
   logic [RATE_W-1:0]     rate_q;
   logic                  gpio_sel_q;
   logic [1:0]            flag_ctl_q, flag_sts_q, flag_irq_q;
   logic                  gpio_q;
   // Datapath state
   dmf_in_frame_s         head_q, tail_q;
   logic                  head_v_q, tail_v_q;
   dmf_out_frame_s        route_q;
   logic                  route_v_q;

   function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                                input logic [AXI_DW-1:0] data,
                                                input logic [3:0]        strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic fits(input logic [1:0] n, input logic [31:0] fs);
      fits = (fs != 32'd0) &&
             (longint'(n) * longint'(MIX_COST) * longint'(fs) <= longint'(CORE_SYSTEM_CLOCK_HZ));
   endfunction : fits

   // Write channel handshakes
   wire aw_take = s_awvalid & awready_q;
   wire w_take  = s_wvalid & wready_q;
   wire do_wr   = aw_held_q & w_held_q & ~bvalid_q;
   wire aw_held_d = (aw_held_q & ~do_wr) | aw_take;
   wire w_held_d  = (w_held_q & ~do_wr) | w_take;
   wire ar_take = s_arvalid & arready_q;

   // Write decode
   wire [11:0] wr_idx     = awaddr_q[13:2];
   wire        wr_mix_hit = wr_idx[11:4] == IDX_MIX_SRC0[11:4];
   wire        wr_ctrl    = do_wr & (wr_idx == IDX_MIX_CTRL);
   wire        wr_rate    = do_wr & (wr_idx == IDX_RATE);
   wire        wr_gsel    = do_wr & (wr_idx == IDX_GPIO_SEL);
   wire        wr_flag    = do_wr & (wr_idx == IDX_FLAG_CTL);
   wire        wr_hit     = wr_mix_hit | (wr_idx == IDX_MIX_CTRL) | (wr_idx == IDX_RATE) |
                            (wr_idx == IDX_GPIO_SEL) | (wr_idx == IDX_FLAG_CTL) |
                            (wr_idx == IDX_FLAG_STS);
   wire [REG_W-1:0] ctrl_wv = merge16(REG_W'(req_q), wdata_q, wstrb_q);

   // Read decode
   wire [11:0] rd_idx     = s_araddr[13:2];
   wire        rd_mix_hit = rd_idx[11:4] == IDX_MIX_SRC0[11:4];
   wire [REG_W-1:0] mix_ctrl_rd = REG_W'(req_q) | (REG_W'(act_q) << MC_ACT_LSB) |
                                  (REG_W'(err_q) << MC_ERR_BIT);
   wire        rd_hit = rd_mix_hit | (rd_idx == IDX_MIX_CTRL) | (rd_idx == IDX_RATE) |
                        (rd_idx == IDX_GPIO_SEL) | (rd_idx == IDX_FLAG_CTL) |
                        (rd_idx == IDX_FLAG_STS);
   wire [REG_W-1:0] rd_val =
      rd_mix_hit                 ? cfg_q[rd_idx[3:0]] :
      (rd_idx == IDX_MIX_CTRL)   ? mix_ctrl_rd :
      (rd_idx == IDX_RATE)       ? REG_W'(rate_q) :
      (rd_idx == IDX_GPIO_SEL)   ? REG_W'(gpio_sel_q) :
      (rd_idx == IDX_FLAG_CTL)   ? REG_W'(flag_ctl_q) :
      (rd_idx == IDX_FLAG_STS)   ? REG_W'(flag_sts_q) : '0;

   // Admission check, left considered before right
   wire [31:0] rate_hz = dmf_rate_hz(rate_q);
   wire [1:0]  want    = ctrl_wv[1:0] & ~act_q;
   wire [1:0]  keep    = act_q & ctrl_wv[1:0];
   wire [1:0]  n0      = {1'b0, keep[0]} + {1'b0, keep[1]};
   wire        grant_l = want[0] & fits(n0 + 2'd1, rate_hz);
   wire [1:0]  n1      = n0 + {1'b0, grant_l};
   wire        grant_r = want[1] & fits(n1 + 2'd1, rate_hz);
   wire [1:0]  act_new = keep | {grant_r, grant_l};
   wire        refuse  = wr_ctrl & |(want & ~{grant_r, grant_l});
   wire        err_clr = wr_ctrl & wstrb_q[1] & wdata_q[MC_ERR_BIT];

   // Flag control: DSP write wins over a bus write in the same cycle
   wire        flag_bus_we = wr_flag & wstrb_q[0];
   wire [1:0]  flag_ctl_d  = dsp_flag_we ? dsp_flag_wdata :
                             flag_bus_we ? wdata_q[FLAG_TWO_BIT:FLAG_ONE_BIT] : flag_ctl_q;

   // Input mixers and source selection
   logic [N_MIX_IN+N_MIX_IN+N_AUX-1:0][SAMPLE_W-1:0] sel_s;
   genvar gi;
   generate
      for (gi = 0; gi < N_MIX_IN + N_MIX_IN + N_AUX; gi++) begin : g_sel
         localparam int CI = (gi < 2 * N_MIX_IN) ? gi : gi - 2 * N_MIX_IN + CFG_AUX0;
         wire [SRC_W-1:0] sel = cfg_q[CI][SRC_W-1:0];
         assign sel_s[gi] = (int'(sel) < N_SRC) ? src_data[sel] : '0;
      end
   endgenerate

   function automatic logic [SAMPLE_W-1:0] mix4(input logic [SAMPLE_W-1:0] a, b, c, d,
                                                input logic [VOL_W-1:0]    vol);
      logic signed [SAMPLE_W+1:0]  sum;
      logic signed [SAMPLE_W+VOL_W+2:0] prod;
      sum  = (SAMPLE_W+2)'($signed(a)) + (SAMPLE_W+2)'($signed(b)) +
             (SAMPLE_W+2)'($signed(c)) + (SAMPLE_W+2)'($signed(d));
      // Widen both operands first so the product cannot wrap at the sum's width
      prod = (SAMPLE_W+VOL_W+3)'(sum >>> 2) * (SAMPLE_W+VOL_W+3)'($signed({1'b0, vol}));
      mix4 = prod[SAMPLE_W+VOL_SHIFT-1:VOL_SHIFT];
   endfunction : mix4

   dmf_in_frame_s frame_w;
   always_comb begin
      frame_w.ch[0] = act_q[0] ? mix4(sel_s[0], sel_s[1], sel_s[2], sel_s[3],
                                      cfg_q[CFG_VOL_L][VOL_W-1:0]) : '0;
      frame_w.ch[1] = act_q[1] ? mix4(sel_s[4], sel_s[5], sel_s[6], sel_s[7],
                                      cfg_q[CFG_VOL_R][VOL_W-1:0]) : '0;
      for (int j = 0; j < N_AUX; j++) begin
         frame_w.ch[2+j] = sel_s[2*N_MIX_IN+j];
      end
   end

   // Two-entry buffer toward the DSP, head is the output
   wire push     = src_valid & ~tail_v_q;
   wire pop      = head_v_q & dsp_in_ready;
   wire to_head  = push & (~head_v_q | (pop & ~tail_v_q));
   wire to_tail  = push & ~to_head;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
         head_q   <= '0;
         tail_q   <= '0;
      end else begin
         head_v_q <= to_head | (head_v_q & ~pop) | (pop & tail_v_q);
         tail_v_q <= to_tail | (tail_v_q & ~pop);
         if (to_head) begin
            head_q <= frame_w;
         end else if (pop & tail_v_q) begin
            head_q <= tail_q;
         end
         if (to_tail) begin
            tail_q <= frame_w;
         end
      end
   end

   // Return path to the core routing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         route_q   <= '0;
         route_v_q <= 1'b0;
      end else begin
         route_v_q <= dsp_out_valid;
         if (dsp_out_valid) begin
            route_q <= dsp_out_frame;
         end
      end
   end

   // AXI4-Lite channel state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         awready_q <= ~aw_held_d;
         wready_q  <= ~w_held_d;
         if (aw_take) begin
            awaddr_q <= s_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid_q  <= 1'b1;
            arready_q <= 1'b0;
            rdata_q   <= AXI_DW'(rd_val);
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q & s_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end else begin
            arready_q <= ~rvalid_q;
         end
      end
   end

   // Mixer config block
   generate
      for (gi = 0; gi < N_CFG; gi++) begin : g_cfg
         localparam logic [REG_W-1:0] RST = (gi == CFG_VOL_L || gi == CFG_VOL_R) ?
                                            VOL_RESET : '0;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cfg_q[gi] <= RST;
            end else if (do_wr & wr_mix_hit & (wr_idx[3:0] == 4'(gi))) begin
               cfg_q[gi] <= merge16(cfg_q[gi], wdata_q, wstrb_q);
            end
         end
      end
   endgenerate

   // Mixer enables, rate and GPIO select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q      <= '0;
         act_q      <= '0;
         err_q      <= 1'b0;
         uc_err_q   <= 1'b0;
         rate_q     <= '0;
         gpio_sel_q <= 1'b0;
      end else begin
         uc_err_q <= refuse;
         err_q    <= refuse | (err_q & ~err_clr);
         if (wr_ctrl) begin
            req_q <= ctrl_wv[1:0];
            act_q <= act_new;
         end
         if (wr_rate & wstrb_q[0]) begin
            rate_q <= wdata_q[RATE_W-1:0];
         end
         if (wr_gsel & wstrb_q[0]) begin
            gpio_sel_q <= wdata_q[0];
         end
      end
   end

   // Flags, edge events and GPIO function
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ctl_q <= '0;
         flag_sts_q <= '0;
         flag_irq_q <= '0;
         gpio_q     <= 1'b0;
      end else begin
         flag_ctl_q <= flag_ctl_d;
         flag_sts_q <= flag_ctl_q;
         flag_irq_q <= flag_ctl_q ^ flag_sts_q;
         gpio_q     <= flag_sts_q[gpio_sel_q];
      end
   end

   assign s_awready             = awready_q;
   assign s_wready              = wready_q;
   assign s_bvalid              = bvalid_q;
   assign s_bresp               = bresp_q;
   assign s_arready             = arready_q;
   assign s_rvalid              = rvalid_q;
   assign s_rdata               = rdata_q;
   assign s_rresp               = rresp_q;
   assign src_ready             = ~tail_v_q;
   assign dsp_in_frame          = head_q;
   assign dsp_in_valid          = head_v_q;
   assign route_out_frame       = route_q;
   assign route_out_valid       = route_v_q;
   assign dsp_rate_select       = rate_q;
   assign dsp_flag_status       = flag_sts_q;
   assign dsp_flag_one_host_irq = flag_irq_q[FLAG_ONE_BIT];
   assign dsp_flag_two_host_irq = flag_irq_q[FLAG_TWO_BIT];
   assign gpio_flag_out         = gpio_q;
   assign underclock_err        = uc_err_q;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_flag_one_edge;
      $changed(flag_ctl_q[FLAG_ONE_BIT]);
   endsequence

   sequence s_flag_one_event;
      ##1 dsp_flag_one_host_irq ##1 (flag_sts_q[FLAG_ONE_BIT] == flag_ctl_q[FLAG_ONE_BIT]);
   endsequence

   chk_flag_edge_event: assert property (s_flag_one_edge |-> s_flag_one_event)
      else $error("flag one edge gave no event");
   chk_flag_event_cause: assert property (dsp_flag_two_host_irq |->
      $past(flag_ctl_q[FLAG_TWO_BIT], 1) != $past(flag_ctl_q[FLAG_TWO_BIT], 2))
      else $error("flag two event without an edge");
   chk_status_follows_ctl: assert property ($stable(flag_ctl_q)[*2] |->
      dsp_flag_status == flag_ctl_q)
      else $error("flag status does not follow control");
   chk_gpio_flag_choice: assert property ($stable(gpio_sel_q) |=>
      gpio_flag_out == $past(flag_sts_q[gpio_sel_q]))
      else $error("gpio shows the wrong flag");
   chk_refuse_keeps_active: assert property (underclock_err |->
      ((act_q & $past(act_q)) == ($past(act_q) & req_q)))
      else $error("refused enable disturbed an active path");
   chk_refuse_sets_err: assert property (underclock_err |-> err_q && act_q != req_q)
      else $error("refusal not flagged");
   chk_active_needs_req: assert property ((act_q & ~req_q) == 2'b00)
      else $error("mixer active without request");
   chk_buffer_takes_word: assert property (src_valid && src_ready |=> dsp_in_valid)
      else $error("accepted frame not offered to dsp");
   chk_route_returns: assert property (dsp_out_valid |=>
      route_out_valid && route_out_frame == $past(dsp_out_frame))
      else $error("dsp output not routed");
   chk_mix_reg_write: assert property (do_wr && wr_mix_hit && wstrb_q[1:0] == 2'b11 |=>
      cfg_q[$past(wr_idx[3:0])] == $past(wdata_q[REG_W-1:0]) ##0 bvalid_q)
      else $error("mixer register write lost");
endmodule : dmf_dsp_wrapper

/* File: pkg/dmf_pkg.sv */
package dmf_pkg;
   // Bus and datapath widths
   localparam int AXI_AW   = 14;
   localparam int AXI_DW   = 32;
   localparam int REG_W    = 16;
   localparam int SAMPLE_W = 24;
   localparam int N_DSP_IN  = 8;
   localparam int N_DSP_OUT = 6;
   localparam int N_MIX_IN  = 4;
   localparam int N_AUX     = 6;
   localparam int N_CFG     = 16;
   localparam int SRC_W     = 8;
   localparam int VOL_W     = 8;
   localparam int VOL_SHIFT = 7;
   localparam int RATE_W    = 4;

   // Register indices, byte address is four times the index
   localparam logic [11:0] IDX_MIX_SRC0 = 12'h940;
   localparam logic [11:0] IDX_MIX_LAST = 12'h94f;
   localparam logic [11:0] IDX_MIX_CTRL = 12'h950;
   localparam logic [11:0] IDX_RATE     = 12'h951;
   localparam logic [11:0] IDX_GPIO_SEL = 12'h952;
   localparam logic [11:0] IDX_FLAG_CTL = 12'hd41;
   localparam logic [11:0] IDX_FLAG_STS = 12'hd42;

   // Positions inside the mixer config block
   localparam int CFG_VOL_L    = 8;
   localparam int CFG_VOL_R    = 9;
   localparam int CFG_AUX0     = 10;
   localparam logic [REG_W-1:0] VOL_RESET = 16'h0080;

   // Mixer control fields
   localparam int MC_ACT_LSB = 4;
   localparam int MC_ERR_BIT = 8;
   localparam int FLAG_ONE_BIT = 0;
   localparam int FLAG_TWO_BIT = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [N_DSP_IN-1:0][SAMPLE_W-1:0] ch;
   } dmf_in_frame_s;

   typedef struct packed {
      logic [N_DSP_OUT-1:0][SAMPLE_W-1:0] ch;
   } dmf_out_frame_s;

   // Sample rate per rate-select code, zero for unsupported codes
   function automatic logic [31:0] dmf_rate_hz(input logic [RATE_W-1:0] code);
      case (code)
         4'h1:    dmf_rate_hz = 32'd12000;
         4'h2:    dmf_rate_hz = 32'd24000;
         4'h3:    dmf_rate_hz = 32'd48000;
         4'h4:    dmf_rate_hz = 32'd96000;
         4'h5:    dmf_rate_hz = 32'd192000;
         4'h9:    dmf_rate_hz = 32'd11025;
         4'ha:    dmf_rate_hz = 32'd22050;
         4'hb:    dmf_rate_hz = 32'd44100;
         4'hc:    dmf_rate_hz = 32'd88200;
         4'hd:    dmf_rate_hz = 32'd176400;
         default: dmf_rate_hz = 32'd0;
      endcase
   endfunction : dmf_rate_hz
endpackage : dmf_pkg

/* File: tb/dmf_dsp_model.sv */
`timescale 1ns/1ps
module dmf_dsp_model (
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // Frames from the wrapper
   input  wire dmf_pkg::dmf_in_frame_s in_frame,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic                   stall,
   // Results back to routing
   output dmf_pkg::dmf_out_frame_s     out_frame,
   output logic                        out_valid,
   // Flag writes
   input  wire logic                   flag_req,
   input  wire logic [1:0]             flag_val,
   output logic                        flag_we,
   output logic [1:0]                  flag_wdata,
   output logic [7:0]                  rx_count
);
   import dmf_pkg::*;
   assign in_ready = !stall;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid  <= 1'b0;
         out_frame  <= '0;
         rx_count   <= 8'h00;
         flag_we    <= 1'b0;
         flag_wdata <= 2'h0;
      end else begin
         out_valid <= in_valid && in_ready;
         // Echo low six channels, scramble when idle
         if (in_valid && in_ready) begin
            out_frame.ch <= in_frame.ch[5:0];
            rx_count     <= rx_count + 8'h01;
         end else begin
            out_frame <= ~out_frame;
         end
         flag_we    <= flag_req;
         flag_wdata <= flag_req ? flag_val : ~flag_wdata;
      end
   end
endmodule : dmf_dsp_model

/* File: tb/dmf_dsp_wrapper_tb.sv */
`timescale 1ns/1ps
module dmf_dsp_wrapper_tb;
   import dmf_pkg::*;
   typedef struct packed {
      logic [11:0] idx;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [1:0]  resp;
   } dmf_row_s;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [13:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, src_ready, dsp_in_valid, dsp_in_ready;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp, flag_wdata, flag_status, flag_val = 2'h0, rsp;
   logic [15:0][SAMPLE_W-1:0] src_data;
   logic src_valid = 0, stall = 0, flag_req = 0, flag_we, out_valid, route_valid;
   logic irq_one, irq_two, gpio_out, uc_err;
   logic [RATE_W-1:0] rate_sel;
   logic [7:0] rx_count;
   dmf_in_frame_s in_frame;
   dmf_out_frame_s out_frame, route_frame, route_last;
   logic [31:0] rd;
   int fail_count = 0, compares = 0, n_one = 0, n_two = 0, n_uc = 0, n_route = 0;
   dmf_row_s rows [6] = '{'{12'h941, 16'h0005, 16'h0005, RESP_OKAY},
      '{12'h949, 16'h0040, 16'h0040, RESP_OKAY}, '{12'h952, 16'h0001, 16'h0001, RESP_OKAY},
      '{12'h951, 16'h0003, 16'h0003, RESP_OKAY}, '{12'hd42, 16'h0003, 16'h0000, RESP_OKAY},
      '{12'h100, 16'h0005, 16'h0000, RESP_SLVERR}};
   always #25 aclk = ~aclk;
   initial for (int i = 0; i < 16; i++) src_data[i] = 24'(i * 256);
   dmf_dsp_wrapper u_dmf_dsp_wrapper (.aclk(aclk), .aresetn(aresetn),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
      .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready), .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
      .dsp_in_frame(in_frame), .dsp_in_valid(dsp_in_valid), .dsp_in_ready(dsp_in_ready),
      .dsp_out_frame(out_frame), .dsp_out_valid(out_valid), .route_out_frame(route_frame),
      .route_out_valid(route_valid), .dsp_rate_select(rate_sel), .dsp_flag_we(flag_we),
      .dsp_flag_wdata(flag_wdata), .dsp_flag_status(flag_status),
      .dsp_flag_one_host_irq(irq_one), .dsp_flag_two_host_irq(irq_two),
      .gpio_flag_out(gpio_out), .underclock_err(uc_err));
   dmf_dsp_model u_dmf_dsp_model (.aclk(aclk), .aresetn(aresetn), .in_frame(in_frame),
      .in_valid(dsp_in_valid), .in_ready(dsp_in_ready), .stall(stall),
      .out_frame(out_frame), .out_valid(out_valid), .flag_req(flag_req),
      .flag_val(flag_val), .flag_we(flag_we), .flag_wdata(flag_wdata), .rx_count(rx_count));
   always @(posedge aclk) begin
      if (aresetn) begin
         n_one <= n_one + (irq_one === 1'b1);
         n_two <= n_two + (irq_two === 1'b1);
         n_uc <= n_uc + (uc_err === 1'b1);
         n_route <= n_route + (route_valid === 1'b1);
         if (route_valid === 1'b1) route_last <= route_frame;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task automatic wr(input logic [11:0] idx, input logic [15:0] d);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [11:0] idx);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd_reg
   task automatic dsp_flag(input logic [1:0] v);
      @(posedge aclk);
      flag_req <= 1'b1;
      flag_val <= v;
      @(posedge aclk);
      flag_req <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : dsp_flag
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(12'h948);
      check(rd, 32'h80);
      rd_reg(IDX_FLAG_CTL);
      check(rd, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         check(rsp, rows[i].resp);
         rd_reg(rows[i].idx);
         check(rd, rows[i].rd);
         check(rsp, rows[i].resp);
      end
      wr(IDX_FLAG_CTL, 16'h1);
      repeat (3) @(posedge aclk);
      check(flag_status, 2'h1);
      wr(IDX_FLAG_CTL, 16'h0);
      repeat (3) @(posedge aclk);
      check(n_one, 2);
      dsp_flag(2'h2);
      check(flag_status, 2'h2);
      check(gpio_out, 1'b1);
      rd_reg(IDX_FLAG_STS);
      check(rd, 32'h2);
      dsp_flag(2'h0);
      check(n_one, 32'd2);
      check(n_two, 32'd2);
      check(gpio_out, 1'b0);
      wr(IDX_RATE, 16'h4);
      wr(IDX_MIX_CTRL, 16'h3);
      rd_reg(IDX_MIX_CTRL);
      check(rd & 32'h130, 32'h110);
      check(n_uc, 1);
      wr(IDX_RATE, 16'h3);
      wr(IDX_MIX_CTRL, 16'h103);
      rd_reg(IDX_MIX_CTRL);
      check(rd & 32'h130, 32'h030);
      check(rate_sel, 4'h3);
      for (int i = 0; i < 4; i++) wr(IDX_MIX_SRC0 + 12'(i), 16'h2);
      wr(12'h94a, 16'h5);
      stall <= 1'b1;
      src_valid <= 1'b1;
      repeat (10) @(posedge aclk);
      check(src_ready, 1'b0);
      check(rx_count, 8'h0);
      stall <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(posedge aclk);
         if (src_ready) break;
      end
      src_valid <= 1'b0;
      repeat (10) @(posedge aclk);
      check(rx_count, 8'h3);
      check(n_route, 3);
      check(route_last.ch[0], 24'h200);
      check(route_last.ch[1], 24'h0);
      check(route_last.ch[2], 24'h500);
      final_report();
   end
endmodule : dmf_dsp_wrapper_tb
